// [byte_op_exec_checker.sv]
// concurrent assertions for the byte-op execute block
`timescale 1ns/1ps
`default_nettype none
`include "byte_op_exec_regs.svh"
module byte_op_exec_checker (
    input wire logic        i_core_clk, // instruction clock
    input wire logic        i_rst,      // synchronous reset
    input wire logic [11:0] i_instr,    // program word
    input wire logic        i_wr,       // debug write strobe
    input wire logic [10:0] o_pc,       // fetch address
    input wire logic [7:0]  o_acc,      // accumulator
    input wire logic        o_zero,     // zero flag
    input wire logic        o_nop_slot  // discarded slot
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------------------
    // slot tracking
    // ------------------------------------------------------------------------
    // the word taken at the last edge is executing now unless the slot is a nop
    logic [11:0] slot;
    always_ff @(posedge i_core_clk) begin
        slot <= i_instr;
    end
    // debug writes win over core results, so those cycles are left out
    wire logic       ex     = !o_nop_slot && !i_wr;
    wire logic       d0     = !slot[`DEST_BIT];
    wire logic [7:0] lit    = slot[7:0];
    wire logic [8:0] k9     = slot[8:0];
    wire logic       is_dec = ex && (slot & `MSK_BYTE) == `OPC_DEC_SKIP;
    wire logic       is_inc = ex && (slot & `MSK_BYTE) == `OPC_INC_SKIP;
    wire logic       is_orf = ex && (slot & `MSK_BYTE) == `OPC_OR_A_F;
    wire logic       is_cpf = ex && (slot & `MSK_BYTE) == `OPC_COPY_F;
    wire logic       is_a2f = ex && (slot & `MSK_COPY_A2F) == `OPC_COPY_A2F;
    wire logic       is_jmp = ex && (slot & `MSK_JUMP) == `OPC_JUMP;
    wire logic       is_orl = ex && (slot & `MSK_LIT) == `OPC_OR_LIT;
    // ------------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------------
    property p_or_lit;
        is_orl |=> o_acc == ($past(o_acc) | $past(lit)) && o_zero == (o_acc == 8'h00);
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("or literal result wrong");
    property p_jump_pc;
        is_jmp |=> o_pc[8:0] == $past(k9);
    endproperty
    a_jump_pc: assert property (p_jump_pc) else $error("jump target low bits wrong");
    property p_jump_nop;
        is_jmp |=> o_nop_slot ##1 !o_nop_slot;
    endproperty
    a_jump_nop: assert property (p_jump_nop) else $error("jump slot count wrong");
    property p_dec_skip;
        is_dec && d0 |=> o_nop_slot == (o_acc == 8'h00);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");
    property p_inc_skip;
        is_inc && d0 |=> o_nop_slot == (o_acc == 8'h00);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");
    property p_flags_kept;
        is_dec || is_inc || is_a2f || is_jmp |=> $stable(o_zero);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flag changed");
    property p_dest_file;
        ((is_dec || is_inc || is_orf || is_cpf) && !d0) || is_a2f || is_jmp |=> $stable(o_acc);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("accumulator changed");
    property p_copy_zero;
        is_cpf && d0 |=> o_zero == (o_acc == 8'h00);
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("copy zero flag wrong");
    property p_or_file;
        is_orf && d0 |=> (o_acc & $past(o_acc)) == $past(o_acc) && o_zero == (o_acc == 8'h00);
    endproperty
    a_or_file: assert property (p_or_file) else $error("or with file wrong");
    c_skip: cover property (is_dec ##1 o_nop_slot);
    c_jump: cover property (is_jmp);
    c_or_lit: cover property (is_orl);
endmodule // byte_op_exec_checker
bind byte_op_skip_jump_exec byte_op_exec_checker i_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_instr(i_instr), .i_wr(i_wr), .o_pc(o_pc), .o_acc(o_acc), .o_zero(o_zero), .o_nop_slot(o_nop_slot));
`default_nettype wire

// [byte_op_exec_pkg.sv]
// types shared by the byte-op execute block
`default_nettype none
package byte_op_exec_pkg;

    // ------------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        st_halted  = 2'b01,
        st_running = 2'b10
    } run_state_t;

    // ------------------------------------------------------------------------
    // decoded operation class
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        op_none,
        op_copy_acc_to_file,
        op_copy_file_to_dest,
        op_or_acc_with_file,
        op_or_literal_into_acc,
        op_decrement_skip_on_null,
        op_increment_skip_on_null,
        op_absolute_jump
    } op_t;

endpackage : byte_op_exec_pkg
`default_nettype wire

// [byte_op_exec_regs.svh]
// offsets, field positions, encodings and reset values of the byte-op execute block
`ifndef BYTE_OP_EXEC_REGS_SVH
`define BYTE_OP_EXEC_REGS_SVH

// ----------------------------------------------------------------------------
// debug port map (word index on the plain register port)
// ----------------------------------------------------------------------------
`define ADDR_FILE_LAST   6'h1f
`define ADDR_ACC         6'h20
`define ADDR_STATUS      6'h21
`define ADDR_PC_LO       6'h22
`define ADDR_PC_HI       6'h23
`define ADDR_CONTROL     6'h24
`define ADDR_STATE       6'h25

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_RUN_BIT     0
`define STAT_Z_BIT       2
`define STAT_PAGE_HI     6
`define STAT_PAGE_LO     5
`define DEST_BIT         5

// ----------------------------------------------------------------------------
// instruction encodings: mask and match per 12-bit word
// ----------------------------------------------------------------------------
`define OPC_NOP          12'h000
`define MSK_COPY_A2F     12'hfe0
`define OPC_COPY_A2F     12'h020
`define MSK_BYTE         12'hfc0
`define OPC_OR_A_F       12'h100
`define OPC_COPY_F       12'h200
`define OPC_DEC_SKIP     12'h2c0
`define OPC_INC_SKIP     12'h3c0
`define MSK_JUMP         12'he00
`define OPC_JUMP         12'ha00
`define MSK_LIT          12'hf00
`define OPC_OR_LIT       12'hd00

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_PC           11'h000

`endif

// [byte_op_skip_jump_exec.sv]
// execute stage for skip, jump, or and move instructions of the 8-bit core
`timescale 1ns/1ps
`default_nettype none
`include "byte_op_exec_regs.svh"

module byte_op_skip_jump_exec
(
    input  wire logic        i_core_clk,  // instruction clock, 10 MHz
    input  wire logic        i_rst,       // synchronous reset, active high
    input  wire logic [11:0] i_instr,     // program word at o_pc, same cycle
    input  wire logic [5:0]  i_addr,      // debug port word index
    input  wire logic [7:0]  i_wdata,     // debug port write data
    input  wire logic        i_wr,        // debug port write strobe
    input  wire logic        i_rd,        // debug port read strobe
    output logic      [7:0]  o_rdata,     // debug read data, cycle after i_rd
    output logic      [10:0] o_pc,        // fetch address
    output logic      [7:0]  o_acc,       // accumulator
    output logic             o_zero,      // zero flag
    output logic             o_nop_slot   // current slot is a discarded word
);
    import byte_op_exec_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    run_state_t  state;
    run_state_t  next_state;
    logic [11:0] instr;          // prefetched word now executing
    logic        flush;          // instr is to be replaced by a nop
    logic [7:0]  acc;
    logic [7:0]  status;
    logic [10:0] pc;
    logic [7:0]  file_reg [0:31];
    logic        run_req;
    logic        keep_running;   // running now and after this edge

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    op_t         op;
    logic [4:0]  f_idx;
    logic        dest_file;
    logic [7:0]  f_val;
    logic [7:0]  result;
    logic        wr_acc;
    logic        wr_file;
    logic        wr_zero;
    logic        take_skip;
    logic        take_jump;
    logic        exec_ok;

    assign f_idx     = instr[4:0];
    assign dest_file = instr[`DEST_BIT];
    assign f_val     = file_reg[f_idx];
    assign exec_ok   = (state == st_running) && !flush;

    // classify the executing word; a flushed slot or halted core decodes as a nop
    always_comb begin
        op = op_none;
        if (exec_ok) begin
            if ((instr & `MSK_COPY_A2F) == `OPC_COPY_A2F) begin
                op = op_copy_acc_to_file;
            end else if ((instr & `MSK_BYTE) == `OPC_COPY_F) begin
                op = op_copy_file_to_dest;
            end else if ((instr & `MSK_BYTE) == `OPC_OR_A_F) begin
                op = op_or_acc_with_file;
            end else if ((instr & `MSK_BYTE) == `OPC_DEC_SKIP) begin
                op = op_decrement_skip_on_null;
            end else if ((instr & `MSK_BYTE) == `OPC_INC_SKIP) begin
                op = op_increment_skip_on_null;
            end else if ((instr & `MSK_JUMP) == `OPC_JUMP) begin
                op = op_absolute_jump;
            end else if ((instr & `MSK_LIT) == `OPC_OR_LIT) begin
                op = op_or_literal_into_acc;
            end
        end
    end

    // ------------------------------------------------------------------------
    // datapath: result value and where it goes
    // ------------------------------------------------------------------------
    always_comb begin
        result    = acc;
        wr_acc    = 1'b0;
        wr_file   = 1'b0;
        wr_zero   = 1'b0;
        take_skip = 1'b0;
        take_jump = 1'b0;
        case (op)
            op_copy_acc_to_file: begin
                result  = acc;
                wr_file = 1'b1;
            end
            op_copy_file_to_dest: begin
                result  = f_val;
                wr_acc  = !dest_file;
                wr_file = dest_file;
                wr_zero = 1'b1;
            end
            op_or_acc_with_file: begin
                result  = acc | f_val;
                wr_acc  = !dest_file;
                wr_file = dest_file;
                wr_zero = 1'b1;
            end
            op_or_literal_into_acc: begin
                result  = acc | instr[7:0];
                wr_acc  = 1'b1;
                wr_zero = 1'b1;
            end
            op_decrement_skip_on_null: begin
                result    = f_val - 8'h01;
                wr_acc    = !dest_file;
                wr_file   = dest_file;
                take_skip = (result == 8'h00);
            end
            op_increment_skip_on_null: begin
                result    = f_val + 8'h01;
                wr_acc    = !dest_file;
                wr_file   = dest_file;
                take_skip = (result == 8'h00);
            end
            op_absolute_jump: begin
                take_jump = 1'b1;
            end
            default: begin
                result = acc;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // debug port write decode
    // ------------------------------------------------------------------------
    // one strobe per target; each register process gives it priority over
    // what the core would write in the same cycle
    logic        dbg_wr_file;
    logic        dbg_wr_acc;
    logic        dbg_wr_status;
    logic        dbg_wr_pc_lo;
    logic        dbg_wr_pc_hi;
    logic        dbg_wr_ctrl;

    assign dbg_wr_file   = i_wr && (i_addr <= `ADDR_FILE_LAST);
    assign dbg_wr_acc    = i_wr && (i_addr == `ADDR_ACC);
    assign dbg_wr_status = i_wr && (i_addr == `ADDR_STATUS);
    assign dbg_wr_pc_lo  = i_wr && (i_addr == `ADDR_PC_LO);
    assign dbg_wr_pc_hi  = i_wr && (i_addr == `ADDR_PC_HI);
    assign dbg_wr_ctrl   = i_wr && (i_addr == `ADDR_CONTROL);

    // ------------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------------
    // apart from reset, the run bit is the only thing that moves the sequencer
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            run_req <= 1'b0;
        end else if (dbg_wr_ctrl) begin
            run_req <= i_wdata[`CTRL_RUN_BIT];
        end
    end

    // halted until the run bit is set; clearing it stops after the current slot
    always_comb begin
        next_state = state;
        case (state)
            st_halted:  next_state = run_req ? st_running : st_halted;
            st_running: next_state = run_req ? st_running : st_halted;
            default:    next_state = st_halted;
        endcase
    end

    // sequencer state register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state <= st_halted;
        end else begin
            state <= next_state;
        end
    end

    // a fetched word is only taken when the core stays running past this edge
    assign keep_running = (state == st_running) && (next_state == st_running);

    // ------------------------------------------------------------------------
    // fetch: prefetch register and program counter
    // ------------------------------------------------------------------------
    // a skip or jump leaves the word just fetched in place but marks it
    // discarded, so it executes as a nop and the instruction costs two cycles
    // a word fetched at the first edge after the run bit drops is not taken: the
    // pc stays on it, so a restart runs it instead of losing it
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            instr <= `OPC_NOP;
            flush <= 1'b1;
        end else if (!keep_running) begin
            instr <= `OPC_NOP;
            flush <= 1'b1;                              // empty slot on start and while halted
        end else begin
            instr <= i_instr;
            flush <= take_skip || take_jump;
        end
    end

    // pc writes from the debug port win over execution
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            pc <= `RST_PC;
        end else if (dbg_wr_pc_lo) begin
            pc <= {pc[10:8], i_wdata};
        end else if (dbg_wr_pc_hi) begin
            pc <= {i_wdata[2:0], pc[7:0]};
        end else if (take_jump) begin
            pc <= {status[`STAT_PAGE_HI:`STAT_PAGE_LO], instr[8:0]};
        end else if (keep_running || take_skip) begin
            pc <= pc + 11'h001;                         // a skip steps over its word even when halting
        end
    end

    // ------------------------------------------------------------------------
    // accumulator, status and file registers
    // ------------------------------------------------------------------------
    // accumulator; a debug write wins over a core result in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            acc <= `RST_BYTE;
        end else if (dbg_wr_acc) begin
            acc <= i_wdata;
        end else if (wr_acc) begin
            acc <= result;
        end
    end

    // only zero-affecting ops touch the flag; skip and jump ops leave it alone
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            status <= `RST_BYTE;
        end else if (dbg_wr_status) begin
            status <= i_wdata;
        end else if (wr_zero) begin
            status[`STAT_Z_BIT] <= (result == 8'h00);
        end
    end

    // file array; a debug file write in the same cycle wins, and the core's file write is dropped whatever entry it targets
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 32; i++) begin
                file_reg[i] <= `RST_BYTE;
            end
        end else if (dbg_wr_file) begin
            file_reg[i_addr[4:0]] <= i_wdata;
        end else if (wr_file) begin
            file_reg[f_idx] <= result;
        end
    end

    // ------------------------------------------------------------------------
    // debug read port: data valid only in the cycle after the strobe
    // ------------------------------------------------------------------------
    // idle cycles show zero so a stale value never passes for a fresh answer
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !i_rd) begin
            o_rdata <= 8'h00;
        end else if (i_addr <= `ADDR_FILE_LAST) begin
            o_rdata <= file_reg[i_addr[4:0]];
        end else begin
            case (i_addr)
                `ADDR_ACC:     o_rdata <= acc;
                `ADDR_STATUS:  o_rdata <= status;
                `ADDR_PC_LO:   o_rdata <= pc[7:0];
                `ADDR_PC_HI:   o_rdata <= {5'h00, pc[10:8]};
                `ADDR_CONTROL: o_rdata <= {7'h00, run_req};
                `ADDR_STATE:   o_rdata <= {6'h00, flush, state == st_running};
                default:       o_rdata <= 8'h00;    // unmapped reads as zero
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------------------
    assign o_pc       = pc;
    assign o_acc      = acc;
    assign o_zero     = status[`STAT_Z_BIT];
    assign o_nop_slot = flush;

endmodule // byte_op_skip_jump_exec
`default_nettype wire

// [byte_op_skip_jump_exec_tb.sv]
// self-checking testbench for the byte-op execute block
`timescale 1ns/1ps
`default_nettype none
`include "byte_op_exec_regs.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module byte_op_skip_jump_exec_tb;
    typedef struct {
        logic [11:0] ins;
        logic [4:0]  f;
        logic [7:0]  fv, acc, st, e_acc, e_f;
        logic        e_z, skip;
    } row_t;
    logic        i_core_clk = 1'b0;
    logic        i_rst, i_wr, i_rd;
    logic [5:0]  i_addr;
    logic [7:0]  i_wdata, o_rdata, o_acc, v;
    logic [11:0] i_instr;
    logic [10:0] o_pc;
    logic        o_zero, o_nop_slot;
    logic [11:0] prog [0:2047];
    row_t        rows [13];
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          cyc = 0;

    byte_op_skip_jump_exec i_byte_op_skip_jump_exec (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr(i_instr),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pc(o_pc),
        .o_acc(o_acc), .o_zero(o_zero), .o_nop_slot(o_nop_slot));

    always #50 i_core_clk = ~i_core_clk;
    // program memory is combinational, as the core expects
    assign i_instr = prog[o_pc];

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        @(negedge i_core_clk);
        d = o_rdata;
    endtask
    // word at 0 under test, word at 1 copies acc to file 31 and shows a skip
    task automatic run_one(input logic [11:0] ins);
        prog[0] = ins;
        prog[1] = 12'h03f;
        wr(`ADDR_PC_LO, 8'h00);
        wr(`ADDR_PC_HI, 8'h00);
        wr(`ADDR_CONTROL, 8'h01);
        repeat (6) @(posedge i_core_clk);
        wr(`ADDR_CONTROL, 8'h00);
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            $display("Error at %0t: run did not finish", $time);
            final_report();
        end
    end

    initial begin
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 6'h00;
        i_wdata = 8'h00;
        for (int a = 0; a < 2048; a++) begin
            prog[a] = `OPC_NOP;
        end
        rows = '{'{12'h2e3, 5'd3, 8'h01, 8'h10, 8'h00, 8'h10, 8'h00, 1'b0, 1'b1},
                 '{12'h2c4, 5'd4, 8'h00, 8'h10, 8'h04, 8'hff, 8'h00, 1'b1, 1'b0},
                 '{12'h3e5, 5'd5, 8'hff, 8'h22, 8'h00, 8'h22, 8'h00, 1'b0, 1'b1},
                 '{12'h3c6, 5'd6, 8'h41, 8'h22, 8'h04, 8'h42, 8'h41, 1'b1, 1'b0},
                 '{12'h3e0, 5'd0, 8'h7f, 8'h01, 8'h04, 8'h01, 8'h80, 1'b1, 1'b0},
                 '{12'hd00, 5'd7, 8'h99, 8'h00, 8'h00, 8'h00, 8'h99, 1'b1, 1'b0},
                 '{12'hda5, 5'd7, 8'h99, 8'h5a, 8'h04, 8'hff, 8'h99, 1'b0, 1'b0},
                 '{12'h128, 5'd8, 8'h0f, 8'hf0, 8'h04, 8'hf0, 8'hff, 1'b0, 1'b0},
                 '{12'h109, 5'd9, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0},
                 '{12'h02a, 5'd10, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0},
                 '{12'h22b, 5'd11, 8'h00, 8'h33, 8'h00, 8'h33, 8'h00, 1'b1, 1'b0},
                 '{12'h20c, 5'd12, 8'h80, 8'h00, 8'h04, 8'h80, 8'h80, 1'b0, 1'b0},
                 '{12'h2de, 5'd30, 8'h01, 8'h10, 8'h00, 8'h00, 8'h01, 1'b0, 1'b1}};
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        `CHK(o_pc, `RST_PC)
        `CHK(o_acc, `RST_BYTE)
        `CHK(o_nop_slot, 1'b1)
        rd(6'h3f, v);
        `CHK(v, 8'h00)
        // ordinary cases: preset, run one word, read back acc, zero flag, the file under test and file 31
        foreach (rows[i]) begin
            wr({1'b0, rows[i].f}, rows[i].fv);
            wr(6'h1f, 8'h5a);
            wr(`ADDR_ACC, rows[i].acc);
            wr(`ADDR_STATUS, rows[i].st);
            run_one(rows[i].ins);
            @(negedge i_core_clk);
            `CHK(o_acc, rows[i].e_acc)
            `CHK(o_zero, rows[i].e_z)
            rd({1'b0, rows[i].f}, v);
            `CHK(v, rows[i].e_f)
            rd(6'h1f, v);
            `CHK(v, rows[i].skip ? 8'h5a : rows[i].e_acc)
        end
        // jump with page bits 10, the word after it must be dropped
        wr(6'h1e, 8'h00);
        wr(6'h1f, 8'h5a);
        wr(`ADDR_ACC, 8'h77);
        wr(`ADDR_STATUS, 8'h44);
        prog[11'h5a5] = 12'h03e;
        run_one(12'hba5);
        rd(6'h1e, v);
        `CHK(v, 8'h77)
        rd(6'h1f, v);
        `CHK(v, 8'h5a)
        rd(`ADDR_STATUS, v);
        `CHK(v, 8'h44)
        rd(`ADDR_PC_HI, v);
        `CHK(v, 8'h05)
        // reset while running: every register returns to its reset value
        wr(`ADDR_CONTROL, 8'h01);
        repeat (3) @(posedge i_core_clk);
        rd(`ADDR_STATE, v);
        `CHK(v, 8'h01)
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        `CHK({o_pc, o_acc, o_zero, o_nop_slot}, {`RST_PC, `RST_BYTE, 1'b0, 1'b1})
        rd(`ADDR_STATE, v);
        `CHK(v, 8'h02)
        rd(6'h1e, v);
        `CHK(v, `RST_BYTE)
        final_report();
    end
endmodule // byte_op_skip_jump_exec_tb
`default_nettype wire
